// ==== port_line_ctrl.sv ====
// Two byte ports with mode logic, alternate functions and Wishbone slave
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
// Contract
// - 000: input, pull-up, no interrupt; pull-up here only while the pull-up option is set
// - 001: floating input, no interrupt
// - 010: pull-up input with interrupt
// - 011: analog input where supported
// - Direction 1, option 0: open drain
// - Direction 1, option 1: push-pull latch
// - Input lines read pin level
// - Timer pins ordinary while enables low
// - Timer enable drives timer signal out
// - Capture pins stay readable inputs
// - Serial-in and clock fed, still readable
// - Serial-out transmits only when open-drain
// - Receive line fed, still readable
// - Transmit line: latch idle, data busy
// - Reset: inputs, pull-up per option
// - Data, direction, option bytes per port
// - Reset clears data, direction, option
module port_line_ctrl #(
  parameter int unsigned width = port_cfg_pkg::data_width
) (
  input wire logic clk_i,                 // Core clock
  input wire logic rst_i,                 // Synchronous reset
  input wire logic [7:0] adr_i,           // Wishbone address
  input wire logic [31:0] dat_i,          // Wishbone write data
  input wire logic [3:0] sel_i,           // Wishbone byte selects
  input wire logic we_i,                  // Wishbone write
  input wire logic cyc_i,                 // Wishbone cycle
  input wire logic stb_i,                 // Wishbone strobe
  output logic [31:0] dat_o,              // Wishbone read data
  output logic ack_o,                     // Wishbone acknowledge
  input wire logic pullup_option_i,       // Pull-up configuration option
  input wire logic [width-1:0] pa_pin_i,  // Port A pin levels
  input wire logic [width-1:0] pd_pin_i,  // Port D pin levels
  output logic [width-1:0] pa_out_o,      // Port A pad output
  output logic [width-1:0] pa_oe_o,       // Port A pad enable
  output logic [width-1:0] pa_pullup_o,   // Port A pull-ups
  output logic [width-1:0] pa_analog_o,   // Port A analog select
  output logic [width-1:0] pa_irq_o,      // Port A interrupt levels
  output logic [width-1:0] pd_out_o,      // Port D pad output
  output logic [width-1:0] pd_oe_o,       // Port D pad enable
  output logic [width-1:0] pd_pullup_o,   // Port D pull-ups
  output logic [width-1:0] pd_analog_o,   // Port D analog select
  output logic [width-1:0] pd_irq_o,      // Port D interrupt levels
  input wire logic pwm_i,                 // Timer pulse-width output
  input wire logic overflow_output_i,     // Timer overflow output
  input wire logic spi_out_i,             // Serial peripheral data out
  input wire logic uart_tx_i,             // UART transmit data
  input wire logic uart_busy_i,           // UART transmission active
  output logic capture_input_a_o,         // Capture trigger A
  output logic capture_input_b_o,         // Capture trigger B
  output logic spi_in_o,                  // Serial data in
  output logic spi_clk_o,                 // Serial clock in
  output logic uart_receive_line_o        // UART receive line
);
  // Configuration registers
  logic [width-1:0] pa_data_q, pa_data_d;
  logic [width-1:0] pa_dir_q, pa_dir_d;
  logic [width-1:0] pa_opt_q, pa_opt_d;
  logic [width-1:0] pd_data_q, pd_data_d;
  logic [width-1:0] pd_dir_q, pd_dir_d;
  logic [width-1:0] pd_opt_q, pd_opt_d;
  logic [4:0] alt_q, alt_d;           // Alternate function control
  logic ack_q, ack_d;                 // Bus acknowledge
  logic [31:0] rdat_q, rdat_d;        // Read data
  logic strap_q, strap_d;             // Captured pull-up option
  // Pin synchronisers
  logic [width-1:0] pa_s1_q, pa_s2_q, pd_s1_q, pd_s2_q;
  logic opt_s1_q, opt_s2_q;
  // Cell outputs
  logic [width-1:0] pa_out, pa_oe, pa_pu, pa_an, pa_irq, pa_rd;
  logic [width-1:0] pd_out, pd_oe, pd_pu, pd_an, pd_irq, pd_rd;
  logic [width-1:0] pa_alt_en, pa_alt_val, pd_alt_en, pd_alt_val;
  logic [width-1:0] pd_od_only;
  logic [width-1:0] pa_out_q, pa_oe_q, pa_pu_q, pa_an_q, pa_irq_q;
  logic [width-1:0] pd_out_q, pd_oe_q, pd_pu_q, pd_an_q, pd_irq_q;
  logic cap_a_q, cap_b_q, sin_q, sclk_q, rx_q;
  logic access;

  // Merge byte lane 0 of a write into a register
  function automatic logic [width-1:0] lane_write(
    input logic [width-1:0] old, input logic [31:0] wd,
    input logic [3:0] sel);
    lane_write = sel[0] ? wd[width-1:0] : old;
  endfunction

  // Two-flop synchronisers for pins and option input
  always_ff @(posedge clk_i) begin
    pa_s1_q <= pa_pin_i;
    pa_s2_q <= pa_s1_q;
    pd_s1_q <= pd_pin_i;
    pd_s2_q <= pd_s1_q;
    opt_s1_q <= pullup_option_i;
    opt_s2_q <= opt_s1_q;
  end

  // Peripheral ownership of output lines
  always_comb begin
    pa_alt_en = '0;
    pa_alt_val = '0;
    pd_alt_en = '0;
    pd_alt_val = '0;
    pd_od_only = '0;
    // Timer outputs own their lines only while enabled
    pa_alt_en[port_cfg_pkg::port_a_line3] =
      alt_q[port_cfg_pkg::pulse_out_enable_bit];
    pa_alt_val[port_cfg_pkg::port_a_line3] = pwm_i;
    pa_alt_en[port_cfg_pkg::port_a_line2] =
      alt_q[port_cfg_pkg::overflow_out_enable_bit];
    pa_alt_val[port_cfg_pkg::port_a_line2] = overflow_output_i;
    // Serial out: only in open-drain mode
    pd_alt_en[port_cfg_pkg::port_d_line3] = 1'b1;
    pd_alt_val[port_cfg_pkg::port_d_line3] = spi_out_i;
    pd_od_only[port_cfg_pkg::port_d_line3] = 1'b1;
    // Transmit line: data during transmission, latch otherwise
    pd_alt_en[port_cfg_pkg::port_d_line5] = uart_busy_i;
    pd_alt_val[port_cfg_pkg::port_d_line5] = uart_tx_i;
  end

  // Per-line mode cells for both ports
  genvar g;
  generate
    for (g = 0; g < width; g++) begin : g_line
      port_line_cell #(.analog_capable(g >= 4)) u_pa (
        .dir_i(pa_dir_q[g]),
        .opt_i(pa_opt_q[g]),
        .latch_i(pa_data_q[g]),
        .alt_en_i(pa_alt_en[g]),
        .alt_val_i(pa_alt_val[g]),
        .od_only_i(1'b0),
        .pin_i(pa_s2_q[g]),
        .pad_out_o(pa_out[g]),
        .pad_oe_o(pa_oe[g]),
        .pullup_o(pa_pu[g]),
        .analog_o(pa_an[g]),
        .irq_o(pa_irq[g]),
        .read_o(pa_rd[g])
      );
      port_line_cell #(.analog_capable(1'b1)) u_pd (
        .dir_i(pd_dir_q[g]),
        .opt_i(pd_opt_q[g]),
        .latch_i(pd_data_q[g]),
        .alt_en_i(pd_alt_en[g]),
        .alt_val_i(pd_alt_val[g]),
        .od_only_i(pd_od_only[g]),
        .pin_i(pd_s2_q[g]),
        .pad_out_o(pd_out[g]),
        .pad_oe_o(pd_oe[g]),
        .pullup_o(pd_pu[g]),
        .analog_o(pd_an[g]),
        .irq_o(pd_irq[g]),
        .read_o(pd_rd[g])
      );
    end
  endgenerate

  // Bus access decode and register next values
  always_comb begin
    access = cyc_i && stb_i && !ack_q;
    pa_data_d = pa_data_q;
    pa_dir_d = pa_dir_q;
    pa_opt_d = pa_opt_q;
    pd_data_d = pd_data_q;
    pd_dir_d = pd_dir_q;
    pd_opt_d = pd_opt_q;
    alt_d = alt_q;
    rdat_d = rdat_q;
    ack_d = access;
    strap_d = opt_s2_q;
    if (access && we_i) begin
      if (adr_i == port_cfg_pkg::port_a_data_off) begin
        pa_data_d = lane_write(pa_data_q, dat_i, sel_i);
      end else if (adr_i == port_cfg_pkg::port_a_dir_off) begin
        pa_dir_d = lane_write(pa_dir_q, dat_i, sel_i);
      end else if (adr_i == port_cfg_pkg::port_a_opt_off) begin
        pa_opt_d = lane_write(pa_opt_q, dat_i, sel_i);
      end else if (adr_i == port_cfg_pkg::port_d_data_off) begin
        pd_data_d = lane_write(pd_data_q, dat_i, sel_i);
      end else if (adr_i == port_cfg_pkg::port_d_dir_off) begin
        pd_dir_d = lane_write(pd_dir_q, dat_i, sel_i);
      end else if (adr_i == port_cfg_pkg::port_d_opt_off) begin
        pd_opt_d = lane_write(pd_opt_q, dat_i, sel_i);
      end else if (adr_i == port_cfg_pkg::alt_ctrl_off && sel_i[0]) begin
        alt_d[3:0] = dat_i[3:0];
      end
    end else if (access) begin
      // Reads: pin levels for inputs, latch for outputs
      if (adr_i == port_cfg_pkg::port_a_data_off) begin
        rdat_d = {24'h00_0000, pa_rd};
      end else if (adr_i == port_cfg_pkg::port_a_dir_off) begin
        rdat_d = {24'h00_0000, pa_dir_q};
      end else if (adr_i == port_cfg_pkg::port_a_opt_off) begin
        rdat_d = {24'h00_0000, pa_opt_q};
      end else if (adr_i == port_cfg_pkg::port_d_data_off) begin
        rdat_d = {24'h00_0000, pd_rd};
      end else if (adr_i == port_cfg_pkg::port_d_dir_off) begin
        rdat_d = {24'h00_0000, pd_dir_q};
      end else if (adr_i == port_cfg_pkg::port_d_opt_off) begin
        rdat_d = {24'h00_0000, pd_opt_q};
      end else if (adr_i == port_cfg_pkg::alt_ctrl_off) begin
        rdat_d = {27'h000_0000, alt_q};
      end else if (adr_i == port_cfg_pkg::pin_status_off) begin
        rdat_d = {16'h0000, pd_s2_q, pa_s2_q};
      end else begin
        rdat_d = port_cfg_pkg::unmapped_read;
      end
    end
    alt_d[port_cfg_pkg::pullup_option_bit] = strap_q;
  end

  // Register update; reset clears every port register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_data_q <= port_cfg_pkg::port_reg_reset;
      pa_dir_q <= port_cfg_pkg::port_reg_reset;
      pa_opt_q <= port_cfg_pkg::port_reg_reset;
      pd_data_q <= port_cfg_pkg::port_reg_reset;
      pd_dir_q <= port_cfg_pkg::port_reg_reset;
      pd_opt_q <= port_cfg_pkg::port_reg_reset;
      alt_q <= port_cfg_pkg::alt_ctrl_reset[4:0];
      ack_q <= 1'b0;
      rdat_q <= port_cfg_pkg::unmapped_read;
      strap_q <= 1'b1;
    end else begin
      pa_data_q <= pa_data_d;
      pa_dir_q <= pa_dir_d;
      pa_opt_q <= pa_opt_d;
      pd_data_q <= pd_data_d;
      pd_dir_q <= pd_dir_d;
      pd_opt_q <= pd_opt_d;
      alt_q <= alt_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      strap_q <= strap_d;
    end
  end

  // Registered pad and peripheral outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_out_q <= '0;
      pa_oe_q <= '0;
      pa_pu_q <= '0;
      pa_an_q <= '0;
      pa_irq_q <= '0;
      pd_out_q <= '0;
      pd_oe_q <= '0;
      pd_pu_q <= '0;
      pd_an_q <= '0;
      pd_irq_q <= '0;
      cap_a_q <= 1'b0;
      cap_b_q <= 1'b0;
      sin_q <= 1'b0;
      sclk_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      pa_out_q <= pa_out;
      pa_oe_q <= pa_oe;
      pa_pu_q <= pa_pu & ({width{strap_q}} | pa_opt_q);
      pa_an_q <= pa_an;
      pa_irq_q <= pa_irq;
      pd_out_q <= pd_out;
      pd_oe_q <= pd_oe;
      pd_pu_q <= pd_pu & ({width{strap_q}} | pd_opt_q);
      pd_an_q <= pd_an;
      pd_irq_q <= pd_irq;
      // Capture only when reload select enables it and line is input
      cap_a_q <= alt_q[port_cfg_pkg::reload_select_lo_bit] &&
        !pa_dir_q[port_cfg_pkg::port_a_line4] &&
        pa_s2_q[port_cfg_pkg::port_a_line4];
      cap_b_q <= alt_q[port_cfg_pkg::reload_select_hi_bit] &&
        !pa_dir_q[port_cfg_pkg::port_a_line5] &&
        pa_s2_q[port_cfg_pkg::port_a_line5];
      sin_q <= pd_s2_q[port_cfg_pkg::port_d_line2];
      sclk_q <= pd_s2_q[port_cfg_pkg::port_d_line1];
      rx_q <= pd_s2_q[port_cfg_pkg::port_d_line4];
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign pa_out_o = pa_out_q;
  assign pa_oe_o = pa_oe_q;
  assign pa_pullup_o = pa_pu_q;
  assign pa_analog_o = pa_an_q;
  assign pa_irq_o = pa_irq_q;
  assign pd_out_o = pd_out_q;
  assign pd_oe_o = pd_oe_q;
  assign pd_pullup_o = pd_pu_q;
  assign pd_analog_o = pd_an_q;
  assign pd_irq_o = pd_irq_q;
  assign capture_input_a_o = cap_a_q;
  assign capture_input_b_o = cap_b_q;
  assign spi_in_o = sin_q;
  assign spi_clk_o = sclk_q;
  assign uart_receive_line_o = rx_q;

  // Bus answers exactly one cycle after request
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("ack missing after request");
  // Ack lasts one cycle
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  // Reset leaves all lines as inputs
  reset_input_a: assert property (@(posedge clk_i)
    rst_i |=> (pa_dir_q == '0 && pd_dir_q == '0 && pd_data_q == '0))
    else $error("port registers not cleared by reset");
  // Pull-up mode enables pull-up with option set
  pullup_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pa_dir_q[0] && !pa_opt_q[0] && !pa_data_q[0] && strap_q)
    |=> pa_pullup_o[0]) else $error("pull-up missing");
  // Floating input has no pull-up
  float_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pa_dir_q[0] && !pa_opt_q[0] && pa_data_q[0]) |=> !pa_pullup_o[0])
    else $error("floating input has pull-up");
  // Interrupt follows pin only in interrupt mode
  irq_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(!pd_dir_q[0] && pd_opt_q[0] && !pd_data_q[0])) |=> !pd_irq_o[0])
    else $error("interrupt active outside interrupt mode");
  // Push-pull drives latch value
  push_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pd_dir_q[0] && pd_opt_q[0]) |=> (pd_oe_o[0] && pd_out_o[0] ==
    $past(pd_data_q[0]))) else $error("push-pull value wrong");
  // Open drain never drives high
  open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pd_dir_q[0] && !pd_opt_q[0]) |=> !pd_out_o[0])
    else $error("open drain drove high");
  // Analog select on capable line
  analog_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pd_dir_q[0] && pd_opt_q[0] && pd_data_q[0]) |=> pd_analog_o[0])
    else $error("analog select missing");
endmodule

// ==== port_cfg_pkg.sv ====
// Package with register map, field positions and reset values for the port
package port_cfg_pkg;
  localparam int unsigned data_width = 8;
  // Register offsets (byte addresses on the bus)
  localparam logic [7:0] port_a_data_off = 8'h00;
  localparam logic [7:0] port_a_dir_off = 8'h04;
  localparam logic [7:0] port_a_opt_off = 8'h08;
  localparam logic [7:0] port_d_data_off = 8'h0C;
  localparam logic [7:0] port_d_dir_off = 8'h10;
  localparam logic [7:0] port_d_opt_off = 8'h14;
  localparam logic [7:0] alt_ctrl_off = 8'h18;
  localparam logic [7:0] pin_status_off = 8'h1C;
  // Alternate control register field positions
  localparam int unsigned pulse_out_enable_bit = 0;
  localparam int unsigned overflow_out_enable_bit = 1;
  localparam int unsigned reload_select_lo_bit = 2;
  localparam int unsigned reload_select_hi_bit = 3;
  localparam int unsigned pullup_option_bit = 4;
  // Port A alternate lines
  localparam int unsigned port_a_line2 = 2;
  localparam int unsigned port_a_line3 = 3;
  localparam int unsigned port_a_line4 = 4;
  localparam int unsigned port_a_line5 = 5;
  // Port D alternate lines
  localparam int unsigned port_d_line1 = 1;
  localparam int unsigned port_d_line2 = 2;
  localparam int unsigned port_d_line3 = 3;
  localparam int unsigned port_d_line4 = 4;
  localparam int unsigned port_d_line5 = 5;
  // Reset values
  localparam logic [7:0] port_reg_reset = 8'h00;
  localparam logic [7:0] alt_ctrl_reset = 8'h10;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;
  // Per-line mode
  typedef enum logic [2:0] {
    mode_in_pullup = 3'b000,
    mode_in_float = 3'b001,
    mode_in_irq = 3'b010,
    mode_in_analog = 3'b011,
    mode_out_od = 3'b100,
    mode_out_pp = 3'b101
  } line_mode_type;
endpackage

// ==== port_line_cell.sv ====
// One port line: mode decode, pad control and interrupt forwarding
`timescale 1ns/1ns
module port_line_cell #(
  parameter bit analog_capable = 1'b1
) (
  input wire logic dir_i,      // Direction bit
  input wire logic opt_i,      // Option bit
  input wire logic latch_i,    // Data latch bit
  input wire logic alt_en_i,   // Peripheral owns the output
  input wire logic alt_val_i,  // Peripheral output value
  input wire logic od_only_i,  // Peripheral drives only when open drain
  input wire logic pin_i,      // Synchronised pin level
  output logic pad_out_o,      // Pad output level
  output logic pad_oe_o,       // Pad driver enable
  output logic pullup_o,       // Pull-up enable
  output logic analog_o,       // Analog mux select
  output logic irq_o,          // Level to interrupt logic
  output logic read_o          // Value seen on a data read
);
  port_cfg_pkg::line_mode_type mode;
  logic drive_val;

  // Mode decode from direction, option and latch
  always_comb begin
    if (dir_i) begin
      mode = opt_i ? port_cfg_pkg::mode_out_pp
                   : port_cfg_pkg::mode_out_od;
    end else begin
      mode = port_cfg_pkg::line_mode_type'({1'b0, opt_i, latch_i});
    end
  end

  // Output value and pad control
  always_comb begin
    drive_val = latch_i;
    if (alt_en_i && (!od_only_i || mode == port_cfg_pkg::mode_out_od)) begin
      drive_val = alt_val_i;
    end
    pad_out_o = 1'b0;
    pad_oe_o = 1'b0;
    pullup_o = 1'b0;
    analog_o = 1'b0;
    irq_o = 1'b0;
    read_o = pin_i;
    case (mode)
      port_cfg_pkg::mode_in_pullup: begin
        pullup_o = 1'b1;
      end
      port_cfg_pkg::mode_in_float: begin
        pullup_o = 1'b0;
      end
      port_cfg_pkg::mode_in_irq: begin
        pullup_o = 1'b1;
        irq_o = pin_i;
      end
      port_cfg_pkg::mode_in_analog: begin
        analog_o = analog_capable;
      end
      port_cfg_pkg::mode_out_od: begin
        pad_out_o = 1'b0;
        pad_oe_o = !drive_val;
        read_o = latch_i;
      end
      default: begin
        pad_out_o = drive_val;
        pad_oe_o = 1'b1;
        read_o = latch_i;
      end
    endcase
  end
endmodule

// ==== port_pin_model.sv ====
// External pin circuitry model: resolves pad drive, stimulus and pull-ups
`timescale 1ns/1ns
module port_pin_model (
  input wire logic clk_i,            // Core clock
  input wire logic [7:0] out_i,      // Pad output level from the port
  input wire logic [7:0] oe_i,       // Pad drive enable from the port
  input wire logic [7:0] pullup_i,   // Pull-up enable from the port
  input wire logic [7:0] ext_en_i,   // External driver active
  input wire logic [7:0] ext_val_i,  // External driver level
  output logic [7:0] pin_o           // Resolved pin level
);
  logic [7:0] float_q = 8'h55;  // Undriven lines wander every cycle

  // Floating lines never hold their last value
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // Port driver first, then outside driver, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) begin
        pin_o[i] = out_i[i];  // Push-pull level or open-drain low
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (pullup_i[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = float_q[i];
      end
    end
  end
endmodule

// ==== port_line_ctrl_tb_top.sv ====
// Self-checking bench for the two-port line mode and alternate logic
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module port_line_ctrl_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0;
  logic stb_i = 1'b0, pullup_option_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'hF;
  logic pwm_i = 1'b0, ovf_i = 1'b0, spi_out_i = 1'b0;
  logic uart_tx_i = 1'b0, uart_busy_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, cap_a, cap_b, spi_in, spi_clk, uart_rx;
  logic [7:0] out [2], oe [2], pu [2], an [2], irq [2], pin [2];
  logic [7:0] dir [2], opt [2], dat [2], ext_val [2];
  logic [3:0] alt = 4'h0;
  logic [31:0] seed = 32'h0000_82D5;  // Start value 33493
  int n_errors = 0, compares = 0;

  // 100 MHz core clock
  always #5 clk_i = ~clk_i;

  port_line_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .pullup_option_i(pullup_option_i), .pa_pin_i(pin[0]),
    .pd_pin_i(pin[1]), .pa_out_o(out[0]), .pa_oe_o(oe[0]),
    .pa_pullup_o(pu[0]), .pa_analog_o(an[0]), .pa_irq_o(irq[0]),
    .pd_out_o(out[1]), .pd_oe_o(oe[1]), .pd_pullup_o(pu[1]),
    .pd_analog_o(an[1]), .pd_irq_o(irq[1]), .pwm_i(pwm_i),
    .overflow_output_i(ovf_i), .spi_out_i(spi_out_i),
    .uart_tx_i(uart_tx_i), .uart_busy_i(uart_busy_i),
    .capture_input_a_o(cap_a), .capture_input_b_o(cap_b),
    .spi_in_o(spi_in), .spi_clk_o(spi_clk), .uart_receive_line_o(uart_rx));

  // Far side of each port; outside drivers act on input lines only
  port_pin_model pins_a (.clk_i(clk_i), .out_i(out[0]), .oe_i(oe[0]),
    .pullup_i(pu[0]), .ext_en_i(~dir[0]), .ext_val_i(ext_val[0]),
    .pin_o(pin[0]));
  port_pin_model pins_d (.clk_i(clk_i), .out_i(out[1]), .oe_i(oe[1]),
    .pullup_i(pu[1]), .ext_en_i(~dir[1]), .ext_val_i(ext_val[1]),
    .pin_o(pin[1]));

  // Xorshift random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Counts and verdict, then stop
  task results;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      n_errors++;
      $display("BAD wb_ack exp 1 got %b", ack_o);
      results();
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Byte write on lane 0, whole register at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, {24'h00_0000, d}, 4'hF, r);
  endtask

  // Reset held for 10 cycles, then settle straps and pin sync
  task reset_dut;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      dir[k] = 8'h00;
      opt[k] = 8'h00;
      dat[k] = 8'h00;
    end
    alt = 4'h0;
    repeat (5) @(posedge clk_i);
  endtask

  // Compare every port output and readback with the reference model
  task automatic check_all;
    logic [7:0] v, d, o, c, p, b;
    logic [31:0] r;
    logic [7:0] e;
    logic [15:0] pe;
    for (int k = 0; k < 2; k++) begin
      d = dir[k];
      o = opt[k];
      p = ext_val[k];
      v = dat[k];
      b = (k == 0) ? port_cfg_pkg::port_a_data_off
                   : port_cfg_pkg::port_d_data_off;
      if (k == 0) begin
        if (alt[0]) v[3] = pwm_i;
        if (alt[1]) v[2] = ovf_i;
        c = 8'hF0;
      end else begin
        if (!o[3]) v[3] = spi_out_i;
        if (uart_busy_i) v[5] = uart_tx_i;
        c = 8'hFF;
      end
      `CHK("oe", d & (o | ~v), oe[k])
      `CHK("out", d & o & v, out[k] & d & (o | ~v))
      e = ~d & ~dat[k] & (o | {8{pullup_option_i}});
      `CHK("pullup", e, pu[k])
      `CHK("analog", ~d & o & dat[k] & c, an[k])
      `CHK("irq", ~d & o & ~dat[k] & p, irq[k])
      wb(1'b0, b, 32'h0000_0000, 4'hF, r);
      `CHK("data_rd", {24'h00_0000, (d & dat[k]) | (~d & p)}, r)
      wb(1'b0, b + 8'h04, 32'h0000_0000, 4'hF, r);
      `CHK("dir_rd", {24'h00_0000, d}, r)
      wb(1'b0, b + 8'h08, 32'h0000_0000, 4'hF, r);
      `CHK("opt_rd", {24'h00_0000, o}, r)
    end
    wb(1'b0, port_cfg_pkg::alt_ctrl_off, 32'h0000_0000, 4'hF, r);
    `CHK("alt_rd", {24'h00_0000, 3'h0, pullup_option_i, alt}, r)
    wb(1'b0, port_cfg_pkg::pin_status_off, 32'h0000_0000, 4'hF, r);
    pe = {~dir[1] & ext_val[1], ~dir[0] & ext_val[0]};
    `CHK("pins", pe, r[15:0] & {~dir[1], ~dir[0]})
    `CHK("pins_hi", 16'h0000, r[31:16])
    `CHK("cap_a", alt[2] & ~dir[0][4] & ext_val[0][4], cap_a)
    `CHK("cap_b", alt[3] & ~dir[0][5] & ext_val[0][5], cap_b)
    if (!dir[1][2]) `CHK("spi_in", ext_val[1][2], spi_in)
    if (!dir[1][1]) `CHK("spi_clk", ext_val[1][1], spi_clk)
    if (!dir[1][4]) `CHK("uart_rx", ext_val[1][4], uart_rx)
  endtask

  // Main sequence
  initial begin
    logic [15:0] m, m1;
    logic [31:0] r;
    ext_val[0] = 8'hA5;
    ext_val[1] = 8'h3C;
    reset_dut();
    check_all();
    $display("test reset_no_pullup done");
    pullup_option_i <= 1'b1;
    reset_dut();
    check_all();
    $display("test reset_pullup done");
    for (int it = 0; it < 40; it++) begin
      for (int k = 0; k < 2; k++) begin
        dir[k] = 8'(rnd());
        opt[k] = 8'(rnd());
        dat[k] = 8'(rnd());
        ext_val[k] <= 8'(rnd());
      end
      // At most one analog line across both ports
      m = {~dir[1] & opt[1] & dat[1], ~dir[0] & opt[0] & dat[0] & 8'hF0};
      m1 = m & (~m + 16'h0001);
      dat[0] = dat[0] & ~(m[7:0] & ~m1[7:0]);
      dat[1] = dat[1] & ~(m[15:8] & ~m1[15:8]);
      alt = 4'(rnd());
      r = rnd();
      pwm_i <= r[0];
      ovf_i <= r[1];
      spi_out_i <= r[2];
      uart_tx_i <= r[3];
      uart_busy_i <= r[4];
      // Pass through input modes before outputs
      for (int k = 0; k < 2; k++) begin
        wr(port_cfg_pkg::port_a_dir_off + 8'(k * 12), 8'h00);
        wr(port_cfg_pkg::port_a_data_off + 8'(k * 12), dat[k]);
        wr(port_cfg_pkg::port_a_opt_off + 8'(k * 12), opt[k]);
        wr(port_cfg_pkg::port_a_dir_off + 8'(k * 12), dir[k]);
      end
      wr(port_cfg_pkg::alt_ctrl_off, {4'h0, alt});
      repeat (5) @(posedge clk_i);
      check_all();
    end
    $display("test random_cfg done");
    // Lane 0 deselected: write must be dropped
    wb(1'b1, port_cfg_pkg::port_a_opt_off, ~{24'h00_0000, opt[0]}, 4'hE, r);
    wb(1'b0, port_cfg_pkg::port_a_opt_off, 32'h0000_0000, 4'hF, r);
    `CHK("sel_rd", {24'h00_0000, opt[0]}, r)
    $display("test byte_select done");
    // Unmapped place acks, reads zero, changes nothing
    wb(1'b1, 8'h20, 32'h0000_00FF, 4'hF, r);
    wb(1'b0, 8'h20, 32'h0000_0000, 4'hF, r);
    `CHK("unmapped", port_cfg_pkg::unmapped_read, r)
    check_all();
    $display("test unmapped done");
    results();
  end
endmodule
